// ===== rtl/sram_port_pkg.sv
// shared constants and pin groups for the flow-through sram data port
package sram_port_pkg;
  localparam int ADDR_W = 19;
  localparam int BYTES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = BYTES * BYTE_W;
  localparam int WORD_W = DATA_W + BYTES;
  localparam int BURST_W = 2;
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic MODE_LINEAR = 1'b0;

  typedef struct packed {
    logic chip_select_first_n;
    logic chip_select_second;
    logic chip_select_third_n;
    logic write_n;
    logic advance_or_load;
    logic [BYTES-1:0] byte_write_n;
    logic [ADDR_W-1:0] addr;
  } ctrl_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [BYTES-1:0] parity_lines;
  } data_pins_t;
endpackage

// ===== rtl/burst_addr_gen.sv
// low address bits of a burst beat, linear or interleaved
`timescale 1ns/100ps
module burst_addr_gen (
  input wire logic [sram_port_pkg::BURST_W-1:0] start,
  input wire logic [sram_port_pkg::BURST_W-1:0] count,
  input wire logic linear,
  output logic [sram_port_pkg::BURST_W-1:0] beat
);
  always_comb begin
    if (linear) begin
      beat = start + count;
    end else begin
      beat = start ^ count;
    end
  end
endmodule

// ===== rtl/sram_data_port.sv
// flow-through burst sram: control qualification, data and parity pins, sleep, test port edges
// Behaviour
// - act on edges only while qualifier low
// - qualifier high never deselects the device
// - sleep request enters low power, contents kept
// - write data captured on rising edge
// - read data from previous edge address
// - output enable low lets pins drive
// - outputs off: write data, emerging, deselected
// - parity lines behave exactly like data
// - strap low linear, high/open interleaved
// - test output changes on test clock fall
// - test inputs sampled on test clock rise
// - selected: first, third low, second high
// - advance steps counter, load takes new address
// - linear burst counts up modulo four
`timescale 1ns/100ps
module sram_data_port (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clock_qualifier_n,
  input wire sram_port_pkg::ctrl_pins_t ctrl,
  input wire sram_port_pkg::data_pins_t data_in,
  output sram_port_pkg::data_pins_t data_out,
  output logic data_oe,
  output logic parity_oe,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_mode_strap,
  input wire logic test_clk,
  input wire logic test_data_in,
  input wire logic test_mode_select,
  output logic test_data_out,
  output logic test_data_out_oe
);
  localparam int DEPTH = 1 << sram_port_pkg::ADDR_W;

  logic [sram_port_pkg::WORD_W-1:0] mem [0:DEPTH-1];

  // asynchronous pins pass two flops before use
  logic [5:0] async_meta_ff;
  logic [5:0] async_sync_ff;
  logic oe_n_s, sleep_s, strap_s, tck_s, tdi_s, tms_s;
  assign {oe_n_s, sleep_s, strap_s, tck_s, tdi_s, tms_s} = async_sync_ff;

  always_ff @(posedge ref_clk) begin
    async_meta_ff <= {output_enable_n, sleep_request, burst_mode_strap, test_clk, test_data_in, test_mode_select};
    async_sync_ff <= async_meta_ff;
  end

  logic asleep_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      asleep_ff <= 1'b0;
    end else begin
      asleep_ff <= sleep_s;
    end
  end

  logic linear_mode;
  assign linear_mode = (strap_s == sram_port_pkg::MODE_LINEAR);

  // a stretched cycle freezes the burst, write and read state, selection included; the drive enables still follow output enable
  logic qualified;
  assign qualified = ~clock_qualifier_n & ~asleep_ff;

  logic active_ff;
  logic is_write_ff;
  logic [sram_port_pkg::ADDR_W-1:0] base_addr_ff;
  logic [sram_port_pkg::BURST_W-1:0] cnt_ff;

  logic selected;
  assign selected = ~ctrl.chip_select_first_n & ctrl.chip_select_second & ~ctrl.chip_select_third_n;

  logic loading;
  assign loading = ~ctrl.advance_or_load;

  logic [sram_port_pkg::BURST_W-1:0] nxt_cnt;
  logic [sram_port_pkg::BURST_W-1:0] gen_start;
  logic [sram_port_pkg::BURST_W-1:0] beat;
  assign nxt_cnt = loading ? sram_port_pkg::BURST_FIRST : cnt_ff + sram_port_pkg::BURST_STEP;
  assign gen_start = loading ? ctrl.addr[sram_port_pkg::BURST_W-1:0] : base_addr_ff[sram_port_pkg::BURST_W-1:0];

  burst_addr_gen u_burst (
    .start(gen_start),
    .count(nxt_cnt),
    .linear(linear_mode),
    .beat(beat)
  );

  logic op_now;
  logic op_write;
  logic [sram_port_pkg::ADDR_W-1:0] op_addr;
  always_comb begin
    if (loading) begin
      op_now = selected;
      op_write = ~ctrl.write_n;
      op_addr = ctrl.addr;
    end else begin
      // advancing ignores chip selects and write enable
      op_now = active_ff;
      op_write = is_write_ff;
      op_addr = {base_addr_ff[sram_port_pkg::ADDR_W-1:sram_port_pkg::BURST_W], beat};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      active_ff <= 1'b0;
      is_write_ff <= 1'b0;
      base_addr_ff <= '0;
      cnt_ff <= sram_port_pkg::BURST_FIRST;
    end else if (qualified) begin
      cnt_ff <= nxt_cnt;
      if (loading) begin
        active_ff <= selected;
        is_write_ff <= ~ctrl.write_n;
        base_addr_ff <= ctrl.addr;
      end
    end
  end

  // write data phase: data arrives one qualified edge after the address
  logic wr_pend_ff;
  logic [sram_port_pkg::ADDR_W-1:0] wr_addr_ff;
  logic [sram_port_pkg::BYTES-1:0] bw_n_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      bw_n_ff <= '1;
    end else if (qualified) begin
      wr_pend_ff <= op_now & op_write;
      wr_addr_ff <= op_addr;
      bw_n_ff <= ctrl.byte_write_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (qualified && wr_pend_ff) begin
      for (int b = 0; b < sram_port_pkg::BYTES; b++) begin
        if (!bw_n_ff[b]) begin
          mem[wr_addr_ff][b*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W] <=
            data_in.data[b*sram_port_pkg::BYTE_W +: sram_port_pkg::BYTE_W];
          mem[wr_addr_ff][sram_port_pkg::DATA_W + b] <= data_in.parity_lines[b];
        end
      end
    end
  end

  // read data is fetched at the address edge, so it stands the very next cycle
  logic rd_phase_ff;
  logic nxt_rd_phase;
  logic [sram_port_pkg::WORD_W-1:0] rd_word_ff;
  // the drive enable is launched with the word it drives; a lagging enable would drive into a write data phase
  assign nxt_rd_phase = qualified ? (op_now & ~op_write) : (rd_phase_ff & ~asleep_ff);
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_phase_ff <= 1'b0;
      rd_word_ff <= '0;
    end else begin
      rd_phase_ff <= nxt_rd_phase;
      if (qualified) begin
        rd_word_ff <= mem[op_addr];
      end
    end
  end

  always_comb begin
    data_out.data = rd_word_ff[sram_port_pkg::DATA_W-1:0];
    data_out.parity_lines = rd_word_ff[sram_port_pkg::WORD_W-1:sram_port_pkg::DATA_W];
  end

  // output enable only gates a read data phase; writes and deselect keep pins off
  logic drive_ok;
  assign drive_ok = nxt_rd_phase & ~oe_n_s;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_oe <= 1'b0;
      parity_oe <= 1'b0;
    end else begin
      data_oe <= drive_ok;
      parity_oe <= drive_ok;
    end
  end

  // test port: the test clock is slow, so its edges are found by oversampling
  logic tck_prev_ff;
  logic tdi_cap_ff;
  logic tms_cap_ff;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tck_prev_ff <= 1'b0;
      tdi_cap_ff <= 1'b0;
      tms_cap_ff <= 1'b1;
      test_data_out <= 1'b0;
      test_data_out_oe <= 1'b0;
    end else begin
      tck_prev_ff <= tck_s;
      if (tck_s && !tck_prev_ff) begin
        tdi_cap_ff <= tdi_s;
        tms_cap_ff <= tms_s;
      end
      if (!tck_s && tck_prev_ff) begin
        test_data_out <= tdi_cap_ff;
        test_data_out_oe <= ~tms_cap_ff;
      end
    end
  end
endmodule

// ===== testbench/sram_port_checker.sv
// pin-level checks on the sram data port
`timescale 1ns/100ps
module sram_port_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clock_qualifier_n,
  input wire sram_port_pkg::ctrl_pins_t ctrl,
  input wire sram_port_pkg::data_pins_t data_out,
  input wire logic data_oe,
  input wire logic parity_oe,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic test_clk,
  input wire logic test_data_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic sel;
  logic ld;
  assign sel = !ctrl.chip_select_first_n && ctrl.chip_select_second && !ctrl.chip_select_third_n;
  assign ld = !clock_qualifier_n && !ctrl.advance_or_load;
  AST_PAR_OE: assert property (parity_oe == data_oe) else $error("parity enable differs");
  AST_STRETCH: assert property (clock_qualifier_n && $past(clock_qualifier_n) && !sleep_request |=> $stable(data_out))
    else $error("output moved in stretch");
  AST_OE_OFF: assert property (output_enable_n [*3] |=> !data_oe) else $error("drive with oe high");
  AST_WR_OFF: assert property (ld && sel && !ctrl.write_n ##1 !clock_qualifier_n && ctrl.advance_or_load
    |-> !data_oe ##1 !data_oe) else $error("drive in write");
  AST_WR_PHASE_OFF: assert property (ld && sel && !ctrl.write_n |=> !data_oe) else $error("drive in write phase");
  AST_DESEL_OFF: assert property (ld && !sel ##1 ld && !sel |-> !data_oe ##1 !data_oe)
    else $error("drive deselected");
  AST_READ_OE: assert property ((!output_enable_n && !sleep_request) [*4] ##0 ld && sel && ctrl.write_n
    ##1 ld && sel && ctrl.write_n && !output_enable_n |-> data_oe ##1 data_oe) else $error("read not driven");
  AST_SLEEP_OFF: assert property (sleep_request [*5] |-> !data_oe) else $error("drive asleep");
  AST_TDO_EDGE: assert property ($changed(test_data_out) |-> !test_clk) else $error("tdo moved high");
endmodule
bind sram_data_port sram_port_checker i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clock_qualifier_n(clock_qualifier_n), .ctrl(ctrl), .data_out(data_out), .data_oe(data_oe),
  .parity_oe(parity_oe), .output_enable_n(output_enable_n), .sleep_request(sleep_request),
  .test_clk(test_clk), .test_data_out(test_data_out));

// ===== testbench/sram_ctrl_model.sv
// memory controller model driving control, write data and qualifier
`timescale 1ns/100ps
module sram_ctrl_model (
  input wire logic ref_clk,
  input wire sram_port_pkg::data_pins_t data_out,
  output logic clock_qualifier_n,
  output sram_port_pkg::ctrl_pins_t ctrl,
  output sram_port_pkg::data_pins_t data_in
);
  logic wr_burst = 1'b0;
  logic pend_v = 1'b0;
  sram_port_pkg::data_pins_t pend = '0;
  initial begin
    clock_qualifier_n = 1'b0;
    ctrl = '1;
    data_in = '0;
  end
  task automatic op(input logic adv, input logic wr, input logic sel, input logic [18:0] a, input logic [3:0] bw,
                    input sram_port_pkg::data_pins_t wd, output sram_port_pkg::data_pins_t seen);
    @(negedge ref_clk);
    seen = data_out;
    clock_qualifier_n = 1'b0;
    // idle lines toggle so stale data never passes for write data
    data_in = pend_v ? pend : ~data_in;
    if (!adv) wr_burst = wr && sel;
    pend_v = wr_burst;
    pend = wd;
    ctrl = '{!sel, sel, !sel, !wr, adv, bw, a};
  endtask
  task automatic stall(input int n);
    @(negedge ref_clk);
    clock_qualifier_n = 1'b1;
    repeat (n - 1) @(negedge ref_clk);
  endtask
endmodule

// ===== testbench/flow_through_sram_data_port_bench.sv
// self-checking bench for the flow-through sram data port
`timescale 1ns/100ps
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %0t %s", $time, m); end end
module flow_through_sram_data_port_bench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic output_enable_n = 1'b0;
  logic sleep_request = 1'b0;
  logic burst_mode_strap = 1'b0;
  logic test_clk = 1'b0;
  logic test_data_in = 1'b0;
  logic test_mode_select = 1'b1;
  logic clock_qualifier_n, data_oe, parity_oe, test_data_out, test_data_out_oe;
  sram_port_pkg::ctrl_pins_t ctrl;
  sram_port_pkg::data_pins_t data_in, data_out, seen [4];
  int bad_count = 0;
  int tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  sram_data_port i_sram_data_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .clock_qualifier_n(clock_qualifier_n),
    .ctrl(ctrl), .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .parity_oe(parity_oe),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .burst_mode_strap(burst_mode_strap),
    .test_clk(test_clk), .test_data_in(test_data_in), .test_mode_select(test_mode_select),
    .test_data_out(test_data_out), .test_data_out_oe(test_data_out_oe));
  sram_ctrl_model i_m (.ref_clk(ref_clk), .data_out(data_out), .clock_qualifier_n(clock_qualifier_n),
    .ctrl(ctrl), .data_in(data_in));
  function automatic sram_port_pkg::data_pins_t w(input int i);
    return 36'h9a5c3e17b ^ (36'(i) * 36'h111111111);
  endfunction
  task ld(input logic wr, input logic [18:0] a, input logic [3:0] bw, input sram_port_pkg::data_pins_t d, input int k);
    i_m.op(1'b0, wr, 1'b1, a, bw, d, seen[k]);
  endtask
  task nop(input int k);
    i_m.op(1'b0, 1'b0, 1'b0, '0, 4'hf, '0, seen[k]);
  endtask
  task burst(input logic strap, input logic [18:0] base);
    logic [1:0] b;
    burst_mode_strap = strap;
    repeat (4) nop(0);
    ld(1'b1, base | 19'h1, 4'h0, w(0), 0);
    for (int k = 1; k < 4; k++) i_m.op(1'b1, 1'b0, 1'b1, '0, 4'h0, w(k), seen[0]);
    for (int j = 0; j < 5; j++) begin
      b = strap ? 2'(j) ^ 2'h1 : 2'(j) + 2'h1;
      if (j < 4) ld(1'b0, base | 19'(b), 4'h0, '0, j % 4); else nop(j % 4);
      if (j > 0) `CHK(seen[j % 4], w(j - 1), "burst beat")
    end
  endtask
  task stretch_bytes;
    sram_port_pkg::data_pins_t e;
    sram_port_pkg::data_pins_t x;
    e = w(7);
    x = w(9);
    e.data[7:0] = x.data[7:0];
    e.parity_lines[0] = x.parity_lines[0];
    ld(1'b1, 19'h40, 4'h0, w(7), 0);
    i_m.stall(3);
    nop(0);
    ld(1'b1, 19'h40, 4'he, x, 0);
    nop(0);
    ld(1'b0, 19'h40, 4'h0, '0, 0);
    nop(0);
    nop(1);
    `CHK(seen[0], e, "stretched or byte write")
  endtask
  task sleep_keep;
    sleep_request = 1'b1;
    output_enable_n = 1'b1;
    repeat (8) nop(0);
    `CHK(data_oe, 1'b0, "driving asleep")
    sleep_request = 1'b0;
    output_enable_n = 1'b0;
    repeat (6) nop(0);
    ld(1'b0, 19'h101, 4'h0, '0, 0);
    // masked write right behind the read: pins must turn off for its data phase
    ld(1'b1, 19'h300, 4'hf, '0, 0);
    `CHK(data_oe, 1'b1, "read not driven")
    nop(1);
    `CHK(data_oe, 1'b0, "driving in write data phase")
    `CHK(seen[0], w(0), "lost in sleep")
  endtask
  task test_port;
    for (int v = 0; v < 2; v++) begin
      test_data_in = v[0];
      test_mode_select = !v[0];
      test_clk = 1'b1;
      repeat (5) @(negedge ref_clk);
      test_data_in = !v[0];
      repeat (5) @(negedge ref_clk);
      test_clk = 1'b0;
      repeat (8) @(negedge ref_clk);
      `CHK(test_data_out, v[0], "test out")
      `CHK(test_data_out_oe, v[0], "test oe")
    end
  endtask
  task close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    sys_rst = 1'b0;
    burst(1'b0, 19'h100);
    burst(1'b1, 19'h200);
    stretch_bytes;
    sleep_keep;
    test_port;
    close_out;
  end
  initial begin
    #20000;
    bad_count++;
    close_out;
  end
endmodule
